// file: rtl/pts_scheduler.sv
/*
  PDO transmission scheduler: one transmit PDO and one receive PDO.
  Assumes the CAN controller hands over whole frames on this clock,
  and that the application input bus is synchronous to it.
*/
`timescale 1ns/1ns
module pts_scheduler
  import pts_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Transmit PDO configuration
  input  wire logic [31:0] txCommId,
  input  wire logic        txTypeWr,
  input  wire logic [7:0]  txTypeIn,
  input  wire logic [15:0] txInhibit,
  input  wire logic [15:0] txEventTimer,
  input  wire logic        txMapWr,
  input  wire logic [3:0]  txMapCountIn,
  input  wire logic        driveMap,
  // Receive PDO and SYNC configuration
  input  wire logic [31:0] rxCommId,
  input  wire logic        rxTypeWr,
  input  wire logic [7:0]  rxTypeIn,
  input  wire logic [15:0] rxEventTimer,
  input  wire logic [31:0] syncPeriodUs,
  // Application side
  input  wire logic [63:0] appInput,
  input  wire logic        appEvent,
  // CAN controller side
  input  wire pts_frame_t  canRx,
  input  wire logic        txAck,
  output pts_frame_t       canTx,
  // Application outputs
  output logic             rtrToApp,
  output logic [63:0]      outData,
  output logic             outUpdate,
  output logic             rxTimeoutErr,
  output logic             syncLossErr,
  // Configuration readback
  output logic [7:0]       txTypeReg,
  output logic [7:0]       rxTypeReg,
  output logic [3:0]       txMapCount
);

  // ****************************************************************
  // Microsecond tick
  // ****************************************************************
  logic [7:0] tickCnt_reg, tickCnt_next;  // Prescaler
  logic       tick_reg, tick_next;        // Shared timer step

  // Prescaler next value
  always_comb begin
    tick_next    = (tickCnt_reg == 8'(TICK_CYCLES - 1));
    tickCnt_next = tick_next ? 8'h00 : tickCnt_reg + 8'h01;
  end

  // Prescaler registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
    end else begin
      tickCnt_reg <= tickCnt_next;
      tick_reg    <= tick_next;
    end
  end

  // ****************************************************************
  // Frame classification
  // ****************************************************************
  logic    syncRx;   // Valid SYNC seen
  logic    txOn;     // Transmit PDO active
  logic    rxOn;     // Receive PDO active
  logic    rtrHit;   // Remote request for our PDO
  logic    rxHit;    // Data for our receive PDO
  pts_tt_t txMode;   // Decoded transmit class
  pts_tt_t rxMode;   // Decoded receive class

  // Zero-byte frame on the SYNC id, see R17
  assign syncRx = canRx.valid && !canRx.rtr && canRx.id == SYNC_COB_ID && canRx.dlc == SYNC_DLC;
  assign txOn   = !txCommId[ID_OFF_BIT];  // see R22
  assign rxOn   = !rxCommId[ID_OFF_BIT];  // see R22
  assign rtrHit = txOn && canRx.valid && canRx.rtr && canRx.id == txCommId[ID_MSB:0];
  // Oversized frames ignored, see R23
  assign rxHit  = rxOn && canRx.valid && !canRx.rtr && canRx.id == rxCommId[ID_MSB:0]
                  && canRx.dlc <= MAX_BYTES;
  assign txMode = pts_decode(txTypeReg);  // see R04
  assign rxMode = pts_decode(rxTypeReg);  // see R04

  // ****************************************************************
  // Timers
  // ****************************************************************
  logic        fire;                  // Transmission launched now
  logic        inhRun, inhExp;        // Inhibit filter
  logic        evtExp;                // Transmit event timer expiry
  logic        wdExp;                 // Receive watchdog expiry
  logic        syncExp;               // SYNC period watchdog expiry
  logic [31:0] inhLoad, evtLoad, wdLoad;

  assign inhLoad = 32'(txInhibit) * 32'(INHIBIT_US);
  assign evtLoad = 32'(txEventTimer) * 32'(EVTMR_US);  // see R16
  assign wdLoad  = 32'(rxEventTimer) * 32'(EVTMR_US);

  // Inhibit restarts on every send, see R14
  pts_timer #(.W(32)) uInhibit (
    .ref_clk(ref_clk), .rstn(rstn), .tick(tick_reg), .restart(fire),
    .load(inhLoad), .expired(inhExp), .running(inhRun));

  // Event timer restarts on every send or reconfiguration, see R02
  pts_timer #(.W(32)) uEvent (
    .ref_clk(ref_clk), .rstn(rstn), .tick(tick_reg), .restart(fire || txTypeWr),
    .load(evtLoad), .expired(evtExp), .running());

  // Receive watchdog rearmed by each arrival, see R03
  pts_timer #(.W(32)) uWatchdog (
    .ref_clk(ref_clk), .rstn(rstn), .tick(tick_reg), .restart(rxHit || rxTypeWr),
    .load(wdLoad), .expired(wdExp), .running());

  // SYNC supervision, zero period means off, see R10
  pts_timer #(.W(32)) uSyncWd (
    .ref_clk(ref_clk), .rstn(rstn), .tick(tick_reg), .restart(syncRx),
    .load(syncPeriodUs), .expired(syncExp), .running());

  // ****************************************************************
  // Transmit scheduling
  // ****************************************************************
  logic [63:0] prevIn_reg, prevIn_next;  // Last seen input
  logic [63:0] snap_reg, snap_next;      // Data for next frame
  logic        pend_reg, pend_next;      // Event since last send
  logic        want_reg, want_next;      // Send requested
  logic [7:0]  syncCnt_reg, syncCnt_next;
  logic        rtr_reg, rtr_next;
  logic [3:0]  map_reg, map_next;
  logic [7:0]  txType_next;
  pts_frame_t  tx_reg, tx_next;
  logic        change, evt;
  logic [63:0] payload;
  logic [3:0]  dlc;

  assign change = (appInput != prevIn_reg);
  // 254 uses the application's own event, 255 an input change, see R13
  assign evt    = (txTypeReg == TT_MFR_EVT) ? appEvent : change;
  // Held requests wait out the inhibit time, see R15
  assign fire   = want_reg && txOn && !inhRun && !tx_reg.valid;
  // Drive layout: status word then actual value, see R21
  assign payload = driveMap ? {32'h0, snap_reg[31:16], snap_reg[15:0]} : snap_reg;
  assign dlc     = driveMap ? DRIVE_BYTES : map_reg;  // see R20

  // Transmit next-state
  always_comb begin
    prevIn_next  = appInput;
    snap_next    = snap_reg;
    pend_next    = pend_reg;
    want_next    = want_reg;
    syncCnt_next = syncCnt_reg;
    rtr_next     = rtrHit;  // Forward remote request, see R18
    map_next     = map_reg;
    txType_next  = txTypeReg;
    tx_next      = tx_reg;
    // Reserved codes leave the old type, see R24
    if (txTypeWr && !pts_reserved(txTypeIn)) begin
      txType_next = txTypeIn;  // see R05
    end
    // Count of mapped objects, at most one frame, see R19
    if (txMapWr && txMapCountIn <= MAX_BYTES) begin
      map_next = txMapCountIn;
    end
    if (txAck) begin
      tx_next.valid = 1'b0;
    end
    if (fire) begin
      tx_next   = '{valid: 1'b1, rtr: 1'b0, id: txCommId[ID_MSB:0], dlc: dlc, data: payload};
      want_next = 1'b0;
      pend_next = 1'b0;
    end
    unique case (txMode)
      PTS_ACYC: begin
        // Sample at SYNC, send only after an event, see R07
        if (syncRx) begin
          snap_next = appInput;
          if (pend_reg) want_next = 1'b1;
        end
      end
      PTS_CYC: begin
        // Every nth SYNC, see R08
        if (syncRx) begin
          snap_next = appInput;
          if (syncCnt_reg + 8'h01 >= txTypeReg) begin
            syncCnt_next = 8'h00;
            want_next    = 1'b1;
          end else begin
            syncCnt_next = syncCnt_reg + 8'h01;
          end
        end
      end
      PTS_SRTR: begin
        // Latch on SYNC, send only when asked, see R11
        if (syncRx) snap_next = appInput;
        if (rtrHit) want_next = 1'b1;
      end
      PTS_ARTR: begin
        // Continuous update, send only when asked, see R12
        snap_next = appInput;
        if (rtrHit) want_next = 1'b1;
      end
      PTS_ASYNC: begin
        // Send on event at once or on timer expiry, see R01 R02
        snap_next = appInput;
        if (evt || evtExp) want_next = 1'b1;
      end
    endcase
    // A change in the send cycle is kept, see R07
    if (change) pend_next = 1'b1;
  end

  // Transmit registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prevIn_reg  <= 64'h0;
      snap_reg    <= 64'h0;
      pend_reg    <= 1'b0;
      want_reg    <= 1'b0;
      syncCnt_reg <= 8'h00;
      rtr_reg     <= 1'b0;
      map_reg     <= MAX_BYTES;
      txTypeReg   <= TT_RESET;
      tx_reg      <= '0;
    end else begin
      prevIn_reg  <= prevIn_next;
      snap_reg    <= snap_next;
      pend_reg    <= pend_next;
      want_reg    <= want_next;
      syncCnt_reg <= syncCnt_next;
      rtr_reg     <= rtr_next;
      map_reg     <= map_next;
      txTypeReg   <= txType_next;
      tx_reg      <= tx_next;
    end
  end

  assign canTx      = tx_reg;
  assign rtrToApp   = rtr_reg;
  assign txMapCount = map_reg;

  // ****************************************************************
  // Receive handling
  // ****************************************************************
  logic [63:0] buf_reg, buf_next;    // Held until SYNC
  logic        bufV_reg, bufV_next;  // Held data valid
  logic [63:0] out_reg, out_next;
  logic        upd_reg, upd_next;
  logic        tmo_reg, tmo_next;
  logic        sle_reg, sle_next;
  logic [7:0]  rxType_next;
  logic        rxSyncType;

  // All types up to 240 wait for SYNC, see R09
  assign rxSyncType = (rxMode == PTS_ACYC) || (rxMode == PTS_CYC);

  // Receive next-state
  always_comb begin
    buf_next    = buf_reg;
    bufV_next   = bufV_reg;
    out_next    = out_reg;
    upd_next    = 1'b0;
    tmo_next    = tmo_reg;
    sle_next    = sle_reg;
    rxType_next = rxTypeReg;
    if (rxTypeWr && !pts_reserved(rxTypeIn)) begin
      rxType_next = rxTypeIn;  // see R05 R24
    end
    if (syncRx) begin
      sle_next = 1'b0;
      // Apply held data at SYNC, see R06
      if (bufV_reg) begin
        out_next  = buf_reg;
        upd_next  = 1'b1;
        bufV_next = 1'b0;
      end
    end
    if (rxHit) begin
      tmo_next = 1'b0;
      if (rxSyncType) begin
        buf_next  = canRx.data;
        bufV_next = 1'b1;
      end else begin
        out_next = canRx.data;
        upd_next = 1'b1;
      end
    end
    // Watchdog error wins over a clearing arrival, see R03
    if (wdExp) tmo_next = 1'b1;
    // Lost SYNC forces outputs to the error state, see R10
    if (syncExp) begin
      sle_next = 1'b1;
      out_next = 64'h0;
      upd_next = 1'b1;
    end
  end

  // Receive registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      buf_reg   <= 64'h0;
      bufV_reg  <= 1'b0;
      out_reg   <= 64'h0;
      upd_reg   <= 1'b0;
      tmo_reg   <= 1'b0;
      sle_reg   <= 1'b0;
      rxTypeReg <= TT_RESET;
    end else begin
      buf_reg   <= buf_next;
      bufV_reg  <= bufV_next;
      out_reg   <= out_next;
      upd_reg   <= upd_next;
      tmo_reg   <= tmo_next;
      sle_reg   <= sle_next;
      rxTypeReg <= rxType_next;
    end
  end

  assign outData      = out_reg;
  assign outUpdate    = upd_reg;
  assign rxTimeoutErr = tmo_reg;
  assign syncLossErr  = sle_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_reserved_kept: assert property (txTypeWr && pts_reserved(txTypeIn) |=> $stable(txTypeReg)) // see R24
    else $error("reserved type stored");
  a_inhibit_gap: assert property (fire && txInhibit != 16'h0 |=> inhRun [*2]) // see R14
    else $error("inhibit gap broken");
  a_rtr_forward: assert property (rtrHit |=> rtrToApp) // see R18
    else $error("remote request not forwarded");
  a_frame_id: assert property ($rose(canTx.valid) |-> canTx.id == $past(txCommId[ID_MSB:0])) // see R22
    else $error("wrong identifier");
  a_dlc_limit: assert property (canTx.valid |-> canTx.dlc <= MAX_BYTES) // see R23
    else $error("payload too long");
  a_sync_apply: assert property (syncRx && bufV_reg && !syncExp |=> outUpdate && outData == $past(buf_reg)) // see R06
    else $error("held data not applied");
  a_wd_flag: assert property (wdExp |=> rxTimeoutErr) // see R03
    else $error("watchdog not flagged");
  a_sync_loss: assert property (syncExp |=> syncLossErr && outData == 64'h0) // see R10
    else $error("sync loss not handled");
  a_off_silent: assert property (!txOn |-> !fire) // see R22
    else $error("disabled PDO sent");
  a_rtr_only: assert property ((txMode == PTS_SRTR || txMode == PTS_ARTR) && !want_reg && !rtrHit |=> !want_reg) // see R11
    else $error("unrequested send");

  c_cyclic_send: cover property (txMode == PTS_CYC && fire);
  c_rtr_send:    cover property (rtrHit ##[1:20] fire);
  c_rx_apply:    cover property (rxHit ##[1:50] outUpdate);

endmodule : pts_scheduler

// file: rtl/pts_pkg.sv
/*
  Constants, types and decode helpers for the PDO transmission scheduler.
  Assumes a 100 MHz system clock and a frame-level CAN controller on the
  same clock.
*/
//
// Contract
// R01 - Event-driven TPDO sent on input change
// R02 - Event timer resends; events restart it
// R03 - RPDO event timer acts as watchdog
// R04 - Decode 8-bit transmission type ranges
// R05 - Transmission type held per PDO set
// R06 - Type 0 RPDO applied at next SYNC
// R07 - Type 0 TPDO sampled at SYNC, event-gated
// R08 - Types 1-240 send every nth SYNC
// R09 - RPDO types 0-240 valid at next SYNC
// R10 - Missing SYNC drives outputs to error
// R11 - Type 252 latches at SYNC, RTR only
// R12 - Type 253 continuous update, RTR only
// R13 - Types 254/255 send on events
// R14 - Inhibit time spaces successive transmissions
// R15 - First change immediate, later ones held
// R16 - Event timer held per TPDO set
// R17 - SYNC is zero-byte high-priority frame
// R18 - Remote request passed to application
// R19 - Mapping count stored in entry zero
// R20 - Digital default mapping in physical order
// R21 - Drive mapping: word then value
// R22 - Identifier bits 0-10; bit 31 disables
// R23 - Payload at most eight bytes
// R24 - Reserved type writes rejected
// R25 - Zero timer setting disables it
package pts_pkg;

  // ****************************************************************
  // Frame layout and identifiers
  // ****************************************************************
  localparam logic [10:0] SYNC_COB_ID = 11'h080;  // Default SYNC identifier
  localparam int          ID_MSB      = 10;       // Top bit of 11-bit id
  localparam int          ID_OFF_BIT  = 31;       // PDO switched off
  localparam logic [3:0]  MAX_BYTES   = 4'h8;     // One CAN frame
  localparam logic [3:0]  DRIVE_BYTES = 4'h4;     // Word plus value
  localparam logic [3:0]  SYNC_DLC    = 4'h0;     // SYNC has no data

  // ****************************************************************
  // Transmission type codes
  // ****************************************************************
  localparam logic [7:0] TT_ACYC     = 8'h00;  // Acyclic synchronous
  localparam logic [7:0] TT_CYC_MAX  = 8'hf0;  // 240
  localparam logic [7:0] TT_SYNC_RTR = 8'hfc;  // 252
  localparam logic [7:0] TT_ASYN_RTR = 8'hfd;  // 253
  localparam logic [7:0] TT_MFR_EVT  = 8'hfe;  // 254
  localparam logic [7:0] TT_RESET    = 8'hff;  // 255 after reset

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;    // 100 MHz
  localparam int TICK_NS       = 1000;  // Timer base of 1 us
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int INHIBIT_US    = 100;   // Inhibit unit
  localparam int EVTMR_US      = 1000;  // Event timer unit (ms)

  // Decoded transmission class
  typedef enum logic [4:0] {
    PTS_ACYC  = 5'b00001,
    PTS_CYC   = 5'b00010,
    PTS_SRTR  = 5'b00100,
    PTS_ARTR  = 5'b01000,
    PTS_ASYNC = 5'b10000
  } pts_tt_t;

  // CAN frame as exchanged with the controller
  typedef struct packed {
    logic        valid;
    logic        rtr;
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [63:0] data;
  } pts_frame_t;

  // Values 241..251 are not usable
  function automatic logic pts_reserved(input logic [7:0] tt);
    return (tt > TT_CYC_MAX) && (tt < TT_SYNC_RTR);
  endfunction : pts_reserved

  // Class of a stored (never reserved) type
  function automatic pts_tt_t pts_decode(input logic [7:0] tt);
    if (tt == TT_ACYC) return PTS_ACYC;
    if (tt <= TT_CYC_MAX) return PTS_CYC;
    if (tt == TT_SYNC_RTR) return PTS_SRTR;
    if (tt == TT_ASYN_RTR) return PTS_ARTR;
    return PTS_ASYNC;
  endfunction : pts_decode

endpackage : pts_pkg

// file: rtl/pts_timer.sv
/*
  Reloadable one-shot down counter stepped by a microsecond tick.
  Assumes tick is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ns
module pts_timer
  import pts_pkg::*;
#(
  parameter int W = 32  // Counter width
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  // Control
  input  wire logic         tick,
  input  wire logic         restart,
  input  wire logic [W-1:0] load,
  // Status
  output logic              expired,
  output logic              running
);

  // ****************************************************************
  // Counter state
  // ****************************************************************
  logic [W-1:0] cnt_reg, cnt_next;  // Remaining ticks
  logic         run_reg, run_next;  // Armed
  logic         exp_reg, exp_next;  // Expiry pulse

  // Next-state of the counter
  always_comb begin
    cnt_next = cnt_reg;
    run_next = run_reg;
    exp_next = 1'b0;
    if (restart) begin
      // Zero load leaves the timer off, see R25
      cnt_next = load;
      run_next = (load != '0);
    end else if (run_reg && tick) begin
      if (cnt_reg <= W'(1)) begin
        exp_next = 1'b1;
        run_next = 1'b0;
      end else begin
        cnt_next = cnt_reg - W'(1);
      end
    end
  end

  // Registers only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      exp_reg <= exp_next;
    end
  end

  assign expired = exp_reg;
  assign running = run_reg;

endmodule : pts_timer

// file: sim/pts_can_peer.sv
/*
  Model of the CAN controller and bus peers on the scheduler's transmit side:
  it accepts each offered frame after a chosen delay and keeps the last one.
  Assumes one frame outstanding and the scheduler's clock and reset.
*/
`timescale 1ns/1ns
module pts_can_peer
  import pts_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // Scheduler side
  input  wire pts_frame_t canTx,
  input  wire logic [3:0] ackDelay,
  output logic            txAck,
  output pts_frame_t      lastFrame,
  // Bench side
  output int              frames
);
  // ****************************************************************
  // Acceptance
  // ****************************************************************
  logic [3:0] waitCnt;  // Cycles the offered frame has waited

  // One ack pulse per frame; a slow delay mimics a busy bus
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      txAck     <= 1'b0;
      waitCnt   <= 4'h0;
      frames    <= 0;
      lastFrame <= '0;
    end else if (txAck) begin
      // Valid drops after the ack, so never ack twice
      txAck   <= 1'b0;
      waitCnt <= 4'h0;
    end else if (canTx.valid) begin
      if (waitCnt >= ackDelay) begin
        txAck     <= 1'b1;
        frames    <= frames + 1;
        lastFrame <= canTx;
      end else begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule : pts_can_peer

// file: sim/pts_scheduler_tb_top.sv
/*
  Self-checking bench for the PDO scheduler: config writes, transmit types,
  inhibit, remote requests, receive at SYNC and SYNC loss.
  Assumes the partner model in pts_can_peer acknowledges transmit frames.
*/
`timescale 1ns/1ns
module pts_scheduler_tb_top
  import pts_pkg::*;
;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic [31:0] txCommId, rxCommId, syncPeriodUs;
  logic        txTypeWr, rxTypeWr, txMapWr, driveMap, appEvent, txAck;
  logic [7:0]  txTypeIn, rxTypeIn, txTypeReg, rxTypeReg;
  logic [15:0] txInhibit, txEventTimer, rxEventTimer;
  logic [3:0]  txMapCountIn, txMapCount, ackDelay;
  logic [63:0] appInput, outData;
  pts_frame_t  canRx, canTx, lastFrame;
  logic        rtrToApp, outUpdate, rxTimeoutErr, syncLossErr, seen;
  int          frames, base, i;
  int          miscompares = 0;
  int          checks = 0;
  // Type writes and the readback each should leave
  logic [7:0]  tv [8] = '{8'h05, 8'hf1, 8'hfb, 8'h00, 8'hf0, 8'hfc, 8'hfd, 8'hfe};
  logic [7:0]  te [8] = '{8'h05, 8'h05, 8'h05, 8'h00, 8'hf0, 8'hfc, 8'hfd, 8'hfe};

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  pts_scheduler uut (.ref_clk(ref_clk), .rstn(rstn), .txCommId(txCommId), .txTypeWr(txTypeWr),
    .txTypeIn(txTypeIn), .txInhibit(txInhibit), .txEventTimer(txEventTimer), .txMapWr(txMapWr),
    .txMapCountIn(txMapCountIn), .driveMap(driveMap), .rxCommId(rxCommId), .rxTypeWr(rxTypeWr),
    .rxTypeIn(rxTypeIn), .rxEventTimer(rxEventTimer), .syncPeriodUs(syncPeriodUs),
    .appInput(appInput), .appEvent(appEvent), .canRx(canRx), .txAck(txAck), .canTx(canTx),
    .rtrToApp(rtrToApp), .outData(outData), .outUpdate(outUpdate), .rxTimeoutErr(rxTimeoutErr),
    .syncLossErr(syncLossErr), .txTypeReg(txTypeReg), .rxTypeReg(rxTypeReg), .txMapCount(txMapCount));

  pts_can_peer peer (.ref_clk(ref_clk), .rstn(rstn), .canTx(canTx), .ackDelay(ackDelay),
    .txAck(txAck), .lastFrame(lastFrame), .frames(frames));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask : check

  task finish_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Pulsed type write to the transmit or receive set
  task cfg(input logic rx, input logic [7:0] v);
    @(posedge ref_clk);
    txTypeWr <= !rx;
    rxTypeWr <= rx;
    txTypeIn <= v;
    rxTypeIn <= v;
    @(posedge ref_clk);
    txTypeWr <= 1'b0;
    rxTypeWr <= 1'b0;
    #1;
  endtask : cfg

  task map(input logic [3:0] v);
    @(posedge ref_clk);
    txMapWr      <= 1'b1;
    txMapCountIn <= v;
    @(posedge ref_clk);
    txMapWr <= 1'b0;
    #1;
  endtask : map

  // One-cycle frame strobe from the bus
  task frame(input logic rtr, input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
    @(posedge ref_clk);
    canRx <= '{1'b1, rtr, id, dlc, d};
    @(posedge ref_clk);
    canRx <= '0;
    #1;
  endtask : frame

  task sync;
    frame(1'b0, SYNC_COB_ID, SYNC_DLC, 64'h0);
  endtask : sync

  task set_in(input logic [63:0] v);
    @(posedge ref_clk);
    appInput <= v;
  endtask : set_in

  // Bounded wait for the partner's frame count
  task wait_frames(input int n, input int bound);
    for (i = 0; i < bound && frames < n; i++) @(posedge ref_clk);
    #1;
    if (frames < n) begin
      miscompares++;
      finish_test();
    end
  endtask : wait_frames

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {txTypeWr, rxTypeWr, txMapWr, driveMap, appEvent} = 5'h0;
    {txTypeIn, rxTypeIn, txMapCountIn, appInput, canRx} = '0;
    {txEventTimer, rxEventTimer, syncPeriodUs} = '0;
    txCommId  = 32'h0000_0181;
    rxCommId  = 32'h0000_0201;
    txInhibit = 16'h0001;  // 100 us, short enough to watch
    ackDelay  = 4'h3;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    cyc(1);
    check(txTypeReg, 8'hff);
    check(rxTypeReg, 8'hff);
    check(txMapCount, 4'h8);
    for (int k = 0; k < 8; k++) begin
      cfg(1'b0, tv[k]);
      check(txTypeReg, te[k]);
    end
    cfg(1'b1, 8'hf5);
    check(rxTypeReg, 8'hff);
    map(4'h9);
    check(txMapCount, 4'h8);
    map(4'h6);
    check(txMapCount, 4'h6);
    $display("test config done");
    // Asynchronous type, then a change inside the inhibit interval
    cfg(1'b0, 8'hff);
    cyc(5);
    base = frames;
    set_in(64'h1122_3344_5566_7788);
    wait_frames(base + 1, 20);
    check(lastFrame.id, 11'h181);
    check(lastFrame.dlc, 4'h6);
    check(lastFrame.data[31:0], 32'h5566_7788);
    set_in(64'h0000_0000_0000_0099);
    cyc(9000);
    check(64'(frames), 64'(base + 1));
    // Zero inhibit from the next send on, so later tests are not throttled
    @(posedge ref_clk);
    txInhibit <= 16'h0;
    wait_frames(base + 2, 2000);
    check(lastFrame.data[31:0], 32'h0000_0099);
    $display("test async done");
    // Switched-off PDO stays silent
    @(posedge ref_clk);
    txCommId <= 32'h8000_0181;
    set_in(64'h0000_0000_0000_00aa);
    cyc(50);
    check(64'(frames), 64'(base + 2));
    @(posedge ref_clk);
    txCommId <= 32'h0000_0181;
    $display("test disable done");
    // Maker event only: an input change alone sends nothing
    cfg(1'b0, 8'hfe);
    cyc(20);
    base = frames;
    set_in(64'h0000_0000_0000_00bb);
    cyc(20);
    check(64'(frames), 64'(base));
    @(posedge ref_clk);
    appEvent <= 1'b1;
    @(posedge ref_clk);
    appEvent <= 1'b0;
    wait_frames(base + 1, 20);
    check(lastFrame.data[31:0], 32'h0000_00bb);
    $display("test event done");
    // Every third SYNC
    cfg(1'b0, 8'h03);
    cyc(20);
    base = frames;
    repeat (6) begin
      sync();
      cyc(20);
    end
    check(64'(frames), 64'(base + 2));
    // Acyclic: only a change since the last send leads to a frame at SYNC
    cfg(1'b0, 8'h00);
    sync();
    cyc(20);
    base = frames;
    sync();
    cyc(20);
    check(64'(frames), 64'(base));
    set_in(64'h0000_0000_0000_0055);
    cyc(20);
    check(64'(frames), 64'(base));
    sync();
    wait_frames(base + 1, 50);
    $display("test sync done");
    // Remote request only, continuous data
    cfg(1'b0, 8'hfd);
    cyc(5);
    base = frames;
    @(posedge ref_clk);
    driveMap <= 1'b1;
    set_in(64'hffff_0000_0000_0066);
    cyc(20);
    check(64'(frames), 64'(base));
    frame(1'b1, 11'h181, 4'h0, 64'h0);
    seen = 1'b0;
    for (i = 0; i < 3; i++) begin
      seen |= (rtrToApp === 1'b1);
      cyc(1);
    end
    check(seen, 1'b1);
    wait_frames(base + 1, 30);
    check(lastFrame.data[31:0], 32'h0000_0066);
    check(lastFrame.dlc, 4'h4);
    check(lastFrame.data, 64'h0000_0000_0000_0066);
    @(posedge ref_clk);
    driveMap <= 1'b0;
    // Remote request only, data latched at SYNC
    cfg(1'b0, 8'hfc);
    set_in(64'h0000_0000_0000_0077);
    sync();
    set_in(64'h0000_0000_0000_0088);
    cyc(20);
    base = frames;
    frame(1'b1, 11'h181, 4'h0, 64'h0);
    wait_frames(base + 1, 30);
    check(lastFrame.data[31:0], 32'h0000_0077);
    $display("test remote done");
    // Receive PDO waits for SYNC
    cfg(1'b1, 8'h00);
    frame(1'b0, 11'h201, 4'h8, 64'hfedc_ba98_7654_3210);
    cyc(10);
    check(outData, 64'h0);
    sync();
    check(outUpdate, 1'b1);
    cyc(3);
    check(outData, 64'hfedc_ba98_7654_3210);
    $display("test receive done");
    // SYNC watchdog of 5 us
    @(posedge ref_clk);
    syncPeriodUs <= 32'h5;
    sync();
    cyc(800);
    check(syncLossErr, 1'b1);
    check(rxTimeoutErr, 1'b0);
    check(outData, 64'h0);
    sync();
    cyc(2);
    check(syncLossErr, 1'b0);
    $display("test sync loss done");
    finish_test();
  end

  // Hang guard
  initial begin
    #1_000_000;
    miscompares++;
    finish_test();
  end
endmodule : pts_scheduler_tb_top
